// file: design/wps_word_program.sv
// Word program command sequencer with status register and error bits
`timescale 1ns/1ps

module wps_word_program (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host bus cycles
  input wire wps_pkg::wps_bus_req_t bus_req,
  output logic [wps_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_rvalid,
  // Array read path and lock lookup
  input wire logic [wps_pkg::DATA_W-1:0] array_rdata,
  output logic [wps_pkg::ADDR_W-1:0] lock_addr,
  input wire logic lock_hit,
  // Programming engine
  output wps_pkg::wps_prog_req_t prog_req,
  input wire logic prog_done,
  input wire logic prog_fail,
  // Supply fault pin, asynchronous
  input wire logic supply_fault,
  // Status view
  output logic [7:0] status
);

  // ****************************************************************
  // Supply fault synchroniser
  // ****************************************************************
  logic sf_s1_r;
  logic sf_s2_r;
  logic sf_s3_r;
  logic sf_level_r;

  // Three stages; level moves only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    sf_s1_r <= supply_fault;
    sf_s2_r <= sf_s1_r;
    sf_s3_r <= sf_s2_r;
    if (srst) begin
      sf_level_r <= 1'b0;
    end else if (sf_s2_r == sf_s3_r) begin
      sf_level_r <= sf_s3_r;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wps_pkg::wps_state_t state_r;
  wps_pkg::wps_state_t state_nxt;
  logic status_mode_r;
  logic status_mode_nxt;
  logic [wps_pkg::ADDR_W-1:0] tgt_addr_r;
  logic err_prog_r;
  logic err_supply_r;
  logic err_lock_r;
  logic prog_start_r;
  logic [wps_pkg::DATA_W-1:0] prog_data_r;

  wire [7:0] cmd = bus_req.wdata[7:0];
  wire in_idle = (state_r == wps_pkg::ST_IDLE);
  wire in_setup = (state_r == wps_pkg::ST_SETUP);
  wire in_busy = (state_r == wps_pkg::ST_BUSY);
  // Any write outside setup is a command
  wire cmd_wr = bus_req.wr && !in_setup;
  wire is_setup = cmd_wr && (cmd == wps_pkg::CMD_PROG_SETUP);
  wire is_rd_array = cmd_wr && (cmd == wps_pkg::CMD_READ_ARRAY);
  wire is_rd_status = cmd_wr && (cmd == wps_pkg::CMD_READ_STATUS);
  wire is_clear = cmd_wr && (cmd == wps_pkg::CMD_CLEAR_STATUS);
  // Setup accepted only when ready and no supply error latched
  wire setup_ok = is_setup && in_idle && !err_supply_r;
  // In setup, the next write is the data word whatever its value
  wire data_wr = bus_req.wr && in_setup;
  wire abort_lock = data_wr && lock_hit;
  wire abort_supply = data_wr && !lock_hit && sf_level_r;
  wire go_prog = data_wr && !lock_hit && !sf_level_r;
  wire done_ok = in_busy && prog_done;

  assign lock_addr = tgt_addr_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state; a setup during busy is simply dropped
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wps_pkg::ST_IDLE: begin
        if (setup_ok) begin
          state_nxt = wps_pkg::ST_SETUP;
        end
      end
      wps_pkg::ST_SETUP: begin
        if (go_prog) begin
          state_nxt = wps_pkg::ST_BUSY;
        end else if (data_wr) begin
          state_nxt = wps_pkg::ST_IDLE;
        end
      end
      wps_pkg::ST_BUSY: begin
        if (prog_done) begin
          state_nxt = wps_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Read mode: setup and data writes switch to status reads
  always_comb begin
    status_mode_nxt = status_mode_r;
    if (is_rd_array) begin
      status_mode_nxt = 1'b0;
    end else if (is_rd_status || is_setup || data_wr) begin
      status_mode_nxt = 1'b1;
    end
  end

  // State, mode and target address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= wps_pkg::ST_IDLE;
      status_mode_r <= 1'b0;
      tgt_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      status_mode_r <= status_mode_nxt;
      if (setup_ok) begin
        tgt_addr_r <= bus_req.addr;
      end
    end
  end

  // One-cycle start pulse with the word to store
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prog_start_r <= 1'b0;
      prog_data_r <= '0;
    end else begin
      prog_start_r <= go_prog;
      if (go_prog) begin
        prog_data_r <= bus_req.wdata;
      end
    end
  end

  assign prog_req.start = prog_start_r;
  assign prog_req.addr = tgt_addr_r;
  assign prog_req.data = prog_data_r;

  // ****************************************************************
  // Sticky error bits
  // ****************************************************************
  // Set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      err_prog_r <= 1'b0;
      err_supply_r <= 1'b0;
      err_lock_r <= 1'b0;
    end else begin
      err_prog_r <= (err_prog_r && !is_clear)
        || (done_ok && prog_fail);
      err_supply_r <= (err_supply_r && !is_clear)
        || abort_supply;
      err_lock_r <= (err_lock_r && !is_clear)
        || abort_lock;
    end
  end

  // Status word; unused bits read as zero
  always_comb begin
    status = 8'h00;
    status[wps_pkg::STS_READY_BIT] = !in_busy;
    status[wps_pkg::STS_PROG_ERR_BIT] = err_prog_r;
    status[wps_pkg::STS_SUPPLY_ERR_BIT] = err_supply_r;
    status[wps_pkg::STS_LOCKED_BIT] = err_lock_r;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Data registered one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_rdata <= '0;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd) begin
        bus_rdata <= status_mode_r ? {8'h00, status}
          : array_rdata;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_setup_enter;
    setup_ok |=> in_setup && status_mode_r;
  endproperty
  a_setup_enter: assert property (p_setup_enter)
    else $error("setup write not taken");

  property p_data_start;
    go_prog |=> prog_start_r && in_busy ##1 !prog_start_r;
  endproperty
  a_data_start: assert property (p_data_start)
    else $error("data write did not start one program");

  property p_status_read;
    bus_req.rd && status_mode_r |=> bus_rvalid
      && bus_rdata == {8'h00, $past(status)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong data");

  // Start pulse and a low ready bit must leave the same edge
  property p_busy_ready;
    prog_start_r |-> !status[wps_pkg::STS_READY_BIT];
  endproperty
  a_busy_ready: assert property (p_busy_ready)
    else $error("ready bit high while busy");

  property p_read_array;
    is_rd_array ##1 (!bus_req.wr) ##1 bus_req.rd
      |=> bus_rdata == $past(array_rdata);
  endproperty
  a_read_array: assert property (p_read_array)
    else $error("array read after FFh failed");

  property p_supply_refuse;
    is_setup && err_supply_r |=> !in_setup;
  endproperty
  a_supply_refuse: assert property (p_supply_refuse)
    else $error("program accepted with supply error set");

  property p_prog_err;
    done_ok && prog_fail |=> err_prog_r && in_idle;
  endproperty
  a_prog_err: assert property (p_prog_err)
    else $error("program failure not flagged");

  property p_lock_abort;
    abort_lock |=> err_lock_r && in_idle && !prog_start_r;
  endproperty
  a_lock_abort: assert property (p_lock_abort)
    else $error("locked block program not aborted");

  property p_sticky;
    (err_prog_r || err_supply_r || err_lock_r) && !is_clear
      |=> (status[4:1] & $past(status[4:1])) == $past(status[4:1]);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error bit cleared without clear command");

  property p_status_cmd;
    is_rd_status |=> status_mode_r;
  endproperty
  a_status_cmd: assert property (p_status_cmd)
    else $error("70h did not select status reads");

  property p_no_start_busy;
    in_busy && is_setup |=> !in_setup && $stable(tgt_addr_r);
  endproperty
  a_no_start_busy: assert property (p_no_start_busy)
    else $error("setup accepted while busy");

  c_good_prog: cover property (go_prog ##[1:50] (done_ok && !prog_fail));
  c_fail_prog: cover property (done_ok && prog_fail);
  c_lock_abort: cover property (abort_lock);
  c_clear_race: cover property (is_clear && done_ok && prog_fail);

endmodule : wps_word_program

// file: design/wps_pkg.sv
// Shared constants and types for the word program and status block
package wps_pkg;

  // ****************************************************************
  // Command codes, taken from the low byte of a bus write
  // ****************************************************************
  localparam logic [7:0] CMD_PROG_SETUP = 8'h41;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // ****************************************************************
  // Status register layout and reset value
  // ****************************************************************
  localparam int STS_READY_BIT = 7;
  localparam int STS_PROG_ERR_BIT = 4;
  localparam int STS_SUPPLY_ERR_BIT = 3;
  localparam int STS_LOCKED_BIT = 1;
  localparam logic [7:0] STS_RESET = 8'h80;

  // Sizes of the host bus
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_BUSY
  } wps_state_t;

  // One host bus cycle: write or read strobe with address and data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wps_bus_req_t;

  // Request towards the array programming engine
  typedef struct packed {
    logic start;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wps_prog_req_t;

endpackage : wps_pkg

// file: testbench/wps_engine_model.sv
// Behavioural programming engine, array word and one locked address
`timescale 1ns/1ps

module wps_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // From the sequencer
  input wire wps_pkg::wps_prog_req_t prog_req,
  input wire logic [23:0] lock_addr,
  // Bench controls
  input wire logic [7:0] delay,
  input wire logic fail_next,
  input wire logic [23:0] locked_addr,
  // To the sequencer
  output logic prog_done,
  output logic prog_fail,
  output logic lock_hit,
  output logic [15:0] array_rdata
);
  logic busy_r;
  logic [7:0] cnt_r;
  logic [15:0] mem_r;

  // Fail flag is only meaningful with done; show garbage otherwise
  assign prog_fail = prog_done ? fail_next : ~fail_next;
  assign lock_hit = (lock_addr == locked_addr);
  assign array_rdata = mem_r;

  // Program runs for delay+1 cycles, word lands only on success
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      prog_done <= 1'b0;
      mem_r <= 16'hA5A5;
    end else begin
      prog_done <= 1'b0;
      if (prog_req.start) begin
        busy_r <= 1'b1;
        cnt_r <= delay;
      end else if (busy_r && cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        prog_done <= 1'b1;
        if (!fail_next) mem_r <= prog_req.data;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : wps_engine_model

// file: testbench/tb_wps_word_program.sv
// Self-checking bench for the word program sequencer
`timescale 1ns/1ps

module tb_wps_word_program;
  logic sys_clk, srst, bus_rvalid, lock_hit, prog_done, prog_fail;
  logic supply_fault, fail_next;
  wps_pkg::wps_bus_req_t bus_req;
  wps_pkg::wps_prog_req_t prog_req;
  logic [15:0] bus_rdata, array_rdata, d;
  logic [23:0] lock_addr, locked_addr;
  logic [7:0] status, delay;
  int miscompares, checked, starts;

  wps_word_program u_wps_word_program (.sys_clk(sys_clk), .srst(srst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .array_rdata(array_rdata), .lock_addr(lock_addr),
    .lock_hit(lock_hit), .prog_req(prog_req), .prog_done(prog_done),
    .prog_fail(prog_fail), .supply_fault(supply_fault),
    .status(status));
  wps_engine_model u_wps_engine_model (.sys_clk(sys_clk), .srst(srst),
    .prog_req(prog_req), .lock_addr(lock_addr), .delay(delay),
    .fail_next(fail_next), .locked_addr(locked_addr),
    .prog_done(prog_done), .prog_fail(prog_fail), .lock_hit(lock_hit),
    .array_rdata(array_rdata));

  // Clock, start counter and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (prog_req.start === 1'b1) starts++;
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Bus cycles: strobe held one edge, read answer looked at next cycle
  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd();
    @(posedge sys_clk);
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    check({15'h0000, bus_rvalid}, 16'h0001);
    d = bus_rdata;
  endtask : rd

  // Data write goes to another address: setup address must win
  task automatic prog(input logic [23:0] a, input logic [15:0] v);
    wr(a, 16'h0041);
    wr(24'h000000, v);
  endtask : prog

  // Host waits for ready before anything else, then checks the flags
  task automatic poll(input logic [7:0] exp);
    wr(24'h000000, 16'h0070);
    d = 16'h0000;
    for (int i = 0; i < 60 && d[7] !== 1'b1; i++) rd();
    check(d, {8'h00, exp});
  endtask : poll

  task automatic t_program();
    check({8'h00, status}, {8'h00, wps_pkg::STS_RESET});
    rd();
    check(d, 16'hA5A5);
    prog(24'h001234, 16'h1234);
    rd();
    check(d, 16'h0000);
    check(prog_req.addr[15:0], 16'h1234);
    check(prog_req.data, 16'h1234);
    poll(8'h80);
    wr(24'h000000, 16'h00FF);
    rd();
    check(d, 16'h1234);
    check(16'(starts), 16'h0001);
  endtask : t_program

  task automatic t_busy();
    delay <= 8'h20;
    prog(24'h000010, 16'h5555);
    prog(24'h000020, 16'h0000);
    rd();
    check(d, 16'h0000);
    poll(8'h80);
    check(16'(starts), 16'h0002);
    check(prog_req.addr[15:0], 16'h0010);
    delay <= 8'h03;
  endtask : t_busy

  task automatic t_fail();
    fail_next <= 1'b1;
    prog(24'h000030, 16'h0F0F);
    poll(8'h90);
    fail_next <= 1'b0;
    wr(24'h000000, 16'h00FF);
    // Clear code sent as the data word must be stored, not obeyed
    prog(24'h000040, 16'h0050);
    poll(8'h90);
    wr(24'h000000, 16'h0050);
    #1;
    check({8'h00, status}, 16'h0080);
  endtask : t_fail

  // Lock and supply faults both abort without a start pulse
  task automatic t_lock();
    locked_addr <= 24'h000050;
    prog(24'h000050, 16'h1111);
    poll(8'h82);
    check(lock_addr[15:0], 16'h0050);
    check(16'(starts), 16'h0004);
    locked_addr <= 24'hFFFFFF;
    wr(24'h000000, 16'h0050);
    supply_fault <= 1'b1;
    repeat (5) @(posedge sys_clk);
    prog(24'h000060, 16'h0000);
    poll(8'h88);
    supply_fault <= 1'b0;
    repeat (5) @(posedge sys_clk);
    prog(24'h000060, 16'h0000);
    poll(8'h88);
    check(16'(starts), 16'h0004);
    wr(24'h000000, 16'h0050);
    prog(24'h000060, 16'h0000);
    poll(8'h80);
    check(16'(starts), 16'h0005);
  endtask : t_lock

  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    bus_req = '0;
    supply_fault = 1'b0;
    fail_next = 1'b0;
    delay = 8'h03;
    locked_addr = 24'hFFFFFF;
    srst = 1'b1;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_program();
    t_busy();
    t_fail();
    t_lock();
    end_sim();
  end
endmodule : tb_wps_word_program
